// File: src/dpr_ctrl.sv
// Purpose: Dual-port controller for the 16K shared dynamic RAM.
// Assumes: Requests held until done; single clock and reset.
// Notes: Local port wins ties over the system bus; refresh wins both.
`timescale 1ns/1ps
// Function
// - Provide 16K bytes of RAM reachable from both ports.
// - Local accesses in 8000 to BFFF hex reach the RAM.
// - The system window base is any 4K-aligned address set by strap.
// - System addresses are 20 bits, covering one megabyte.
// - An option reserves 8K or 12K for local use with no system window.
// - Refresh runs automatically regardless of which port is active.
// - In slave mode both local and system masters reach the RAM.
// - Local RAM accesses never request the system bus.
// - In slave mode the local processor may not take the system bus.
// - System-bus accesses to local I/O and resources are refused.
// - In master mode the local processor may use the system bus.
// - Memory protect blocks RAM reads and writes while on battery back-up.
// - A system write to the window base raises the flag interrupt.
// - A local read of the base address clears the flag interrupt.
module dpr_ctrl #(
  parameter int REFRESH_INTERVAL = dpr_pkg::REFRESH_CYCLES
)
(
  // Clock, enable and reset.
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_enable,
  // Configuration straps.
  input wire logic i_slave_mode,
  input wire logic [dpr_pkg::BASE_W-1:0] i_sys_base,
  input wire logic [1:0] i_reserve,
  input wire logic i_battery,
  // Local processor port.
  input wire logic i_loc_request,
  input wire logic i_loc_write,
  input wire logic [15:0] i_loc_address,
  input wire logic [7:0] i_loc_wdata,
  output logic o_loc_ram_hit,
  output logic o_loc_done,
  output logic [7:0] o_loc_rdata,
  output logic o_loc_bus_request,
  // System bus slave port.
  input wire logic i_sys_request,
  input wire logic i_sys_write,
  input wire logic i_sys_io,
  input wire logic [dpr_pkg::SYS_AW-1:0] i_sys_address,
  input wire logic [7:0] i_sys_wdata,
  output logic o_sys_hit,
  output logic o_sys_done,
  output logic [7:0] o_sys_rdata,
  // Flag interrupt.
  output logic o_flag_irq
);
  import dpr_pkg::*;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DONE = 2'b10
  } dpr_state_t;

  dpr_state_t state;
  dpr_state_t next_state;
  dpr_owner_t owner;
  dpr_owner_t next_owner;
  logic [1:0] count;
  logic [1:0] next_count;
  logic flag;
  logic next_flag;
  logic [7:0] loc_rdata;
  logic [7:0] next_loc_rdata;
  logic [7:0] sys_rdata;
  logic [7:0] next_sys_rdata;
  logic loc_done;
  logic next_loc_done;
  logic sys_done;
  logic next_sys_done;
  logic done_pulse;
  logic next_done_pulse;
  logic loc_hit;
  logic sys_hit;
  logic [RAM_AW-1:0] sys_offset;
  logic [RAM_AW-1:0] rsv_bytes;
  logic [SYS_AW-1:0] win_lo;
  logic [SYS_AW:0] win_end;
  logic loc_go;
  logic sys_go;
  logic ref_req;
  logic ref_ack;
  logic [6:0] ref_row;
  logic ram_strobe;
  logic ram_write;
  logic [RAM_AW-1:0] ram_address;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic flag_set;
  logic flag_clear;

  // Local decode is a fixed window.
  assign loc_hit = (i_loc_address >= LOCAL_BASE)
    && (i_loc_address <= LOCAL_LAST);

  always_comb
  begin
    unique case (i_reserve)
      RSV_8K: rsv_bytes = RSV_8K_BYTES;
      RSV_12K: rsv_bytes = RSV_12K_BYTES;
      default: rsv_bytes = '0;
    endcase
  end

  // The reserved part sits at the bottom of the RAM and is not mapped.
  assign win_lo = {i_sys_base, {SYS_ALIGN_BITS{1'b0}}};
  assign win_end = {1'b0, win_lo}
    + (SYS_AW + 1)'(RAM_BYTES) - {7'h00, rsv_bytes};
  assign sys_offset = RAM_AW'(i_sys_address - win_lo) + rsv_bytes;
  // A full 20-bit compare places the window in the megabyte space.
  assign sys_hit = i_slave_mode && !i_sys_io
    && (i_sys_address >= win_lo)
    && ({1'b0, i_sys_address} < win_end);

  assign loc_go = i_loc_request && loc_hit && !loc_done;
  assign sys_go = i_sys_request && sys_hit && !sys_done;

  // Arbiter and cycle sequencer.
  always_comb
  begin
    next_state = state;
    next_owner = owner;
    next_count = count;
    ref_ack = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        next_count = 2'(RAM_CYCLE - 1);
        if (ref_req)
        begin
          next_owner = OWN_REFRESH;
          next_state = ST_BUSY;
          ref_ack = 1'b1;
        end
        else if (loc_go)
        begin
          next_owner = OWN_LOCAL;
          next_state = ST_BUSY;
        end
        else if (sys_go)
        begin
          next_owner = OWN_SYS;
          next_state = ST_BUSY;
        end
      end
      ST_BUSY:
      begin
        next_count = count - 2'h1;
        if (count == 2'h1)
        begin
          next_state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // RAM drive; protect blocks reads and writes while running on battery.
  always_comb
  begin
    ram_strobe = (state == ST_BUSY) && (count == 2'h1)
      && (owner != OWN_REFRESH);
    ram_write = 1'b0;
    ram_address = {7'h00, ref_row};
    ram_wdata = i_loc_wdata;
    if (owner == OWN_LOCAL)
    begin
      ram_address = i_loc_address[RAM_AW-1:0];
      ram_write = i_loc_write;
    end
    else if (owner == OWN_SYS)
    begin
      ram_address = sys_offset;
      ram_write = i_sys_write;
      ram_wdata = i_sys_wdata;
    end
    if (i_battery)
    begin
      ram_strobe = 1'b0;
      ram_write = 1'b0;
    end
  end

  // Flag interrupt: set wins over clear.
  assign flag_set = (state == ST_DONE) && (owner == OWN_SYS)
    && i_sys_write && (i_sys_address == win_lo);
  assign flag_clear = (state == ST_DONE) && (owner == OWN_LOCAL)
    && !i_loc_write && (i_loc_address == LOCAL_BASE);

  always_comb
  begin
    next_flag = flag;
    if (flag_clear)
    begin
      next_flag = 1'b0;
    end
    if (flag_set)
    begin
      next_flag = 1'b1;
    end
    next_loc_done = loc_done && i_loc_request;
    next_sys_done = sys_done && i_sys_request;
    next_loc_rdata = loc_rdata;
    next_sys_rdata = sys_rdata;
    // Marks the single idle cycle that follows the end of an access.
    next_done_pulse = (state == ST_DONE);
    if (state == ST_DONE && owner == OWN_LOCAL)
    begin
      next_loc_done = 1'b1;
      next_loc_rdata = ram_rdata;
    end
    if (state == ST_DONE && owner == OWN_SYS)
    begin
      next_sys_done = 1'b1;
      next_sys_rdata = ram_rdata;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state <= ST_IDLE;
      owner <= OWN_LOCAL;
      count <= '0;
      flag <= 1'b0;
      loc_done <= 1'b0;
      sys_done <= 1'b0;
      loc_rdata <= '0;
      sys_rdata <= '0;
      done_pulse <= 1'b0;
    end
    else if (i_enable)
    begin
      state <= next_state;
      owner <= next_owner;
      count <= next_count;
      flag <= next_flag;
      loc_done <= next_loc_done;
      sys_done <= next_sys_done;
      loc_rdata <= next_loc_rdata;
      sys_rdata <= next_sys_rdata;
      done_pulse <= next_done_pulse;
    end
  end

  // Done is a one-cycle pulse on the first idle cycle after the access.
  // The held done bit only keeps a standing request from a second take.
  assign o_loc_done = loc_done && done_pulse && (state == ST_IDLE)
    && (owner == OWN_LOCAL) && i_loc_request;
  assign o_sys_done = sys_done && done_pulse && (state == ST_IDLE)
    && (owner == OWN_SYS) && i_sys_request;
  assign o_loc_rdata = loc_rdata;
  assign o_sys_rdata = sys_rdata;
  assign o_loc_ram_hit = loc_hit;
  assign o_sys_hit = sys_hit;
  assign o_flag_irq = flag;
  // Off-board requests go out only in master mode, never for RAM.
  assign o_loc_bus_request = i_loc_request && !loc_hit
    && !i_slave_mode;

  dpr_refresh #(
    .INTERVAL(REFRESH_INTERVAL)
  ) u_refresh (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_enable(i_enable),
    .i_ack(ref_ack),
    .o_request(ref_req),
    .o_row(ref_row)
  );

  dpr_ram #(
    .AW(RAM_AW)
  ) u_ram (
    .i_clock(i_clock),
    .i_enable(i_enable),
    .i_write(ram_write),
    .i_strobe(ram_strobe),
    .i_address(ram_address),
    .i_wdata(ram_wdata),
    .o_rdata(ram_rdata)
  );
endmodule

// File: src/dpr_pkg.sv
// Purpose: Shared constants for the dual-port shared RAM controller.
// Assumes: 40 MHz board clock, byte-wide data path.
// Notes: Window sizes and refresh timing live here.
package dpr_pkg;
  localparam int RAM_BYTES = 16384;
  localparam int RAM_AW = 14;
  localparam logic [15:0] LOCAL_BASE = 16'h8000;
  localparam logic [15:0] LOCAL_LAST = 16'hbfff;
  localparam int SYS_AW = 20;
  localparam int SYS_ALIGN_BITS = 12;
  localparam int BASE_W = SYS_AW - SYS_ALIGN_BITS;
  // Reserve option codes: none, 8K local-only, 12K local-only.
  localparam logic [1:0] RSV_NONE = 2'h0;
  localparam logic [1:0] RSV_8K = 2'h1;
  localparam logic [1:0] RSV_12K = 2'h2;
  localparam logic [RAM_AW-1:0] RSV_8K_BYTES = 14'h2000;
  localparam logic [RAM_AW-1:0] RSV_12K_BYTES = 14'h3000;
  // Refresh interval in nanoseconds and derived cycles (rounded down).
  localparam int CLOCK_NS = 25;
  localparam int REFRESH_NS = 15600;
  localparam int REFRESH_CYCLES = REFRESH_NS / CLOCK_NS;
  localparam int REFRESH_W = 10;
  localparam int REFRESH_ROWS = 128;
  // Length of one RAM cycle in clocks.
  localparam int RAM_CYCLE = 3;
  typedef enum logic [1:0]
  {
    OWN_LOCAL = 2'b00,
    OWN_SYS = 2'b01,
    OWN_REFRESH = 2'b10
  } dpr_owner_t;
endpackage

// File: src/dpr_ram.sv
// Purpose: Byte-wide storage array with registered read data.
// Assumes: One access per enabled cycle.
// Notes: Refresh cycles never strobe the array; storage is static here.
`timescale 1ns/1ps
module dpr_ram #(
  parameter int AW = 14
)
(
  // Clock.
  input wire logic i_clock,
  input wire logic i_enable,
  // Access.
  input wire logic i_write,
  input wire logic i_strobe,
  input wire logic [AW-1:0] i_address,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_clock)
  begin
    if (i_enable && i_strobe)
    begin
      if (i_write)
      begin
        mem[i_address] <= i_wdata;
      end
      o_rdata <= mem[i_address];
    end
  end
endmodule

// File: src/dpr_refresh.sv
// Purpose: Refresh request timer and row counter.
// Assumes: Request held until acknowledged by the arbiter.
// Notes: Timer keeps running during owned cycles so refresh stays on time.
`timescale 1ns/1ps
module dpr_refresh #(
  parameter int INTERVAL = dpr_pkg::REFRESH_CYCLES
)
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_enable,
  // Arbiter side.
  input wire logic i_ack,
  output logic o_request,
  output logic [6:0] o_row
);
  import dpr_pkg::*;
  logic [REFRESH_W-1:0] timer;
  logic [REFRESH_W-1:0] next_timer;
  logic next_request;
  logic [6:0] next_row;

  always_comb
  begin
    next_timer = timer + 10'h001;
    next_request = o_request;
    next_row = o_row;
    // A new tick in the cycle of an acknowledge must not be lost.
    if (i_ack)
    begin
      next_request = 1'b0;
      next_row = o_row + 7'h01;
    end
    if (timer == REFRESH_W'(INTERVAL - 1))
    begin
      next_timer = '0;
      next_request = 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      timer <= '0;
      o_request <= 1'b0;
      o_row <= '0;
    end
    else if (i_enable)
    begin
      timer <= next_timer;
      o_request <= next_request;
      o_row <= next_row;
    end
  end
endmodule

// File: verif/dpr_ctrl_properties.sv
// Purpose: Port assertions for the shared RAM controller.
// Assumes: Sees only the dpr_ctrl ports.
// Notes: Bound to every dpr_ctrl instance.
`timescale 1ns/1ps
module dpr_ctrl_properties
  import dpr_pkg::*;
#(
  parameter int REFRESH_INTERVAL = REFRESH_CYCLES
)
(
  // Clock, reset and straps.
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_slave_mode,
  input wire logic [BASE_W-1:0] i_sys_base,
  input wire logic [1:0] i_reserve,
  input wire logic i_battery,
  // Local port.
  input wire logic i_loc_request,
  input wire logic i_loc_write,
  input wire logic [15:0] i_loc_address,
  input wire logic o_loc_ram_hit,
  input wire logic o_loc_done,
  input wire logic o_loc_bus_request,
  // System port.
  input wire logic i_sys_request,
  input wire logic i_sys_write,
  input wire logic i_sys_io,
  input wire logic [SYS_AW-1:0] i_sys_address,
  input wire logic o_sys_hit,
  input wire logic o_sys_done,
  input wire logic o_flag_irq
);
  logic [SYS_AW-1:0] span;
  always_comb
  begin
    span = 20'h04000;
    if (i_reserve == RSV_8K)
      span = 20'h02000;
    if (i_reserve == RSV_12K)
      span = 20'h01000;
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  sequence s_base_write;
    o_sys_done && i_sys_write && !i_battery &&
      i_sys_address == {i_sys_base, 12'h000};
  endsequence
  sequence s_base_read;
    o_loc_done && !i_loc_write && i_loc_address == LOCAL_BASE;
  endsequence
  a_loc_decode: assert property (o_loc_ram_hit ==
    (i_loc_address >= LOCAL_BASE && i_loc_address <= LOCAL_LAST))
    else $error("local decode wrong");
  a_local_no_bus: assert property (o_loc_ram_hit |->
    !o_loc_bus_request) else $error("RAM access asked for bus");
  a_slave_no_bus: assert property (i_slave_mode |->
    !o_loc_bus_request) else $error("slave asked for bus");
  a_sys_io_refused: assert property (i_sys_io |-> !o_sys_hit)
    else $error("io cycle accepted");
  a_master_no_sys: assert property (!i_slave_mode |-> !o_sys_hit)
    else $error("system hit in master mode");
  a_sys_span: assert property (o_sys_hit |->
    (i_sys_address - {i_sys_base, 12'h000}) < span)
    else $error("system hit outside window");
  a_one_done: assert property (o_loc_done || o_sys_done |=>
    !o_loc_done && !o_sys_done) else $error("grants overlap");
  a_loc_bound: assert property ($rose(i_loc_request) &&
    o_loc_ram_hit |-> ##[3:30] o_loc_done) else $error("local late");
  a_sys_bound: assert property ($rose(i_sys_request) &&
    o_sys_hit |-> ##[3:30] o_sys_done) else $error("system late");
  a_flag_set: assert property (s_base_write |->
    ##[0:2] o_flag_irq) else $error("flag not raised");
  a_flag_clear: assert property (s_base_read |->
    ##[1:2] !o_flag_irq) else $error("flag not cleared");
endmodule
bind dpr_ctrl dpr_ctrl_properties
  #(.REFRESH_INTERVAL(REFRESH_INTERVAL)) i_props (.i_clock(i_clock),
  .i_reset(i_reset), .i_slave_mode(i_slave_mode),
  .i_sys_base(i_sys_base), .i_reserve(i_reserve), .i_battery(i_battery),
  .i_loc_request(i_loc_request), .i_loc_write(i_loc_write),
  .i_loc_address(i_loc_address), .o_loc_ram_hit(o_loc_ram_hit),
  .o_loc_done(o_loc_done), .o_loc_bus_request(o_loc_bus_request),
  .i_sys_request(i_sys_request), .i_sys_write(i_sys_write),
  .i_sys_io(i_sys_io), .i_sys_address(i_sys_address),
  .o_sys_hit(o_sys_hit), .o_sys_done(o_sys_done),
  .o_flag_irq(o_flag_irq));

// File: verif/dpr_sys_master.sv
// Purpose: Off-board system bus master model.
// Assumes: Started by a one-cycle go; holds until done.
// Notes: Gives up after 41 waiting cycles, as a refused cycle never ends.
`timescale 1ns/1ps
module dpr_sys_master
  import dpr_pkg::*;
(
  // Clock and command.
  input wire logic i_clock,
  input wire logic i_go,
  input wire logic i_write,
  input wire logic i_io,
  input wire logic [SYS_AW-1:0] i_address,
  input wire logic [7:0] i_wdata,
  input wire logic i_done,
  // Bus side.
  output logic o_request = 1'b0,
  output logic o_write = 1'b0,
  output logic o_io = 1'b0,
  output logic [SYS_AW-1:0] o_address = 20'h00000,
  output logic [7:0] o_wdata = 8'h00,
  // Result.
  output logic o_fin = 1'b0,
  output logic o_ok = 1'b0
);
  int wait_n = 0;
  logic seen = 1'b0;
  // The only master on the bus; released write, address and data lines show inverted junk.
  always @(negedge i_clock)
  begin
    o_fin <= 1'b0;
    if (o_request && (seen || wait_n > 40))
    begin
      o_request <= 1'b0;
      o_fin <= 1'b1;
      o_ok <= seen;
      o_write <= ~o_write;
      o_address <= ~o_address;
      o_wdata <= ~o_wdata;
    end
    else if (o_request)
    begin
      seen <= i_done;
      wait_n <= wait_n + 1;
    end
    else if (i_go)
    begin
      o_request <= 1'b1;
      o_write <= i_write;
      o_io <= i_io;
      o_address <= i_address;
      o_wdata <= i_wdata;
      seen <= 1'b0;
      wait_n <= 0;
    end
  end
endmodule

// File: verif/tb.sv
// Purpose: Self-checking bench for the shared RAM controller.
// Assumes: Refresh interval shortened to 8 cycles.
// Notes: Local port driven here, system port by the master model.
`timescale 1ns/1ps
module tb;
  import dpr_pkg::*;
  logic i_clock = 0, i_reset = 1, i_enable = 1, i_slave_mode = 1;
  logic [7:0] i_sys_base = 8'hfc, i_loc_wdata = 8'h00;
  logic [1:0] i_reserve = 2'h0;
  logic i_battery = 0, i_loc_request = 0, i_loc_write = 0;
  logic [15:0] i_loc_address = 16'h0000;
  wire i_sys_request, i_sys_write, i_sys_io, o_loc_ram_hit, o_loc_done;
  wire o_loc_bus_request, o_sys_hit, o_sys_done, o_flag_irq, fin, ok;
  wire [19:0] i_sys_address;
  wire [7:0] i_sys_wdata, o_loc_rdata, o_sys_rdata;
  logic go = 0, cw = 0, cio = 0;
  logic [19:0] ca = 20'h00000;
  logic [7:0] cd = 8'h00, q;
  int err_total = 0, n_compared = 0, cyc = 0;
  time tl, ts;
  dpr_ctrl #(.REFRESH_INTERVAL(8)) i_dut (.i_clock(i_clock),
    .i_reset(i_reset), .i_enable(i_enable), .i_slave_mode(i_slave_mode),
    .i_sys_base(i_sys_base), .i_reserve(i_reserve), .i_battery(i_battery),
    .i_loc_request(i_loc_request), .i_loc_write(i_loc_write),
    .i_loc_address(i_loc_address), .i_loc_wdata(i_loc_wdata),
    .o_loc_ram_hit(o_loc_ram_hit), .o_loc_done(o_loc_done),
    .o_loc_rdata(o_loc_rdata), .o_loc_bus_request(o_loc_bus_request),
    .i_sys_request(i_sys_request), .i_sys_write(i_sys_write),
    .i_sys_io(i_sys_io), .i_sys_address(i_sys_address),
    .i_sys_wdata(i_sys_wdata), .o_sys_hit(o_sys_hit),
    .o_sys_done(o_sys_done), .o_sys_rdata(o_sys_rdata),
    .o_flag_irq(o_flag_irq));
  dpr_sys_master i_master (.i_clock(i_clock), .i_go(go), .i_write(cw),
    .i_io(cio), .i_address(ca), .i_wdata(cd), .i_done(o_sys_done),
    .o_request(i_sys_request), .o_write(i_sys_write), .o_io(i_sys_io),
    .o_address(i_sys_address), .o_wdata(i_sys_wdata), .o_fin(fin),
    .o_ok(ok));
  initial
  begin
    forever #12.5 i_clock = ~i_clock;
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic lx(input logic w, input logic [15:0] a,
    input logic [7:0] d);
    int k;
    @(negedge i_clock);
    i_loc_request = 1;
    i_loc_write = w;
    i_loc_address = a;
    i_loc_wdata = d;
    for (k = 0; k < 40 && o_loc_done !== 1'b1; k++)
      @(negedge i_clock);
    chk(o_loc_done, 1);
    q = o_loc_rdata;
    tl = $time;
    @(negedge i_clock);
    i_loc_request = 0;
    i_loc_address = ~a;
  endtask
  task automatic sx(input logic w, input logic io, input logic [19:0] a,
    input logic [7:0] d, input logic ok_exp);
    int k;
    @(posedge i_clock);
    go <= 1;
    cw <= w;
    cio <= io;
    ca <= a;
    cd <= d;
    @(negedge i_clock);
    go <= 0;
    for (k = 0; k < 60 && fin !== 1'b1; k++)
      @(posedge i_clock);
    chk(fin, 1);
    q = o_sys_rdata;
    ts = $time;
    chk(ok, ok_exp);
  endtask
  task automatic t_share;
    sx(1, 0, 20'hfc010, 8'h3c, 1);
    lx(0, 16'h8010, 8'h00);
    chk(q, 8'h3c);
    lx(1, 16'hbfff, 8'h77);
    sx(0, 0, 20'hfffff, 8'h00, 1);
    chk(q, 8'h77);
    $display("share end");
  endtask
  task automatic t_refuse;
    sx(1, 1, 20'hfc020, 8'h11, 0);
    @(negedge i_clock);
    i_loc_request = 1;
    i_loc_address = 16'h7f00;
    @(negedge i_clock);
    chk(o_loc_ram_hit, 0);
    chk(o_loc_bus_request, 0);
    i_slave_mode = 0;
    @(negedge i_clock);
    chk(o_loc_bus_request, 1);
    i_loc_request = 0;
    sx(1, 0, 20'hfc020, 8'h11, 0);
    i_slave_mode = 1;
    $display("refuse end");
  endtask
  task automatic t_reserve;
    for (int r = 1; r < 3; r++)
    begin
      @(negedge i_clock);
      i_reserve = r[1:0];
      sx(1, 0, 20'hfc000, r[7:0], 1);
      lx(0, r == 1 ? 16'ha000 : 16'hb000, 8'h00);
      chk(q, r[7:0]);
      sx(1, 0, r == 1 ? 20'hfe000 : 20'hfd000, 8'h00, 0);
    end
    @(negedge i_clock);
    i_reserve = 2'h0;
    $display("reserve end");
  endtask
  task automatic t_flag;
    chk(o_flag_irq, 1);
    lx(0, 16'h8000, 8'h00);
    @(negedge i_clock);
    chk(o_flag_irq, 0);
    sx(1, 0, 20'hfc000, 8'h5e, 1);
    chk(o_flag_irq, 1);
    lx(0, 16'h8001, 8'h00);
    chk(o_flag_irq, 1);
    lx(0, 16'h8000, 8'h00);
    @(negedge i_clock);
    chk(o_flag_irq, 0);
    $display("flag end");
  endtask
  task automatic t_other;
    fork
      sx(1, 0, 20'hfc030, 8'h66, 1);
      begin
        @(posedge i_clock);
        lx(1, 16'h8040, 8'h99);
      end
    join
    chk(tl < ts, 1);
    lx(1, 16'h8020, 8'h5a);
    i_battery = 1;
    lx(1, 16'h8020, 8'ha5);
    i_battery = 0;
    lx(0, 16'h8020, 8'h00);
    chk(q, 8'h5a);
    $display("contend battery end");
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      conclude();
    end
  end
  initial
  begin
    repeat (6) @(negedge i_clock);
    i_reset = 0;
    i_enable = 0;
    repeat (3) @(negedge i_clock);
    i_enable = 1;
    t_share();
    t_refuse();
    t_reserve();
    t_flag();
    t_other();
    conclude();
  end
endmodule
